// *** include/rlc_pkg.sv ***
/*
 * Constants, encodings and types of the remote/local bus control block.
 * Assumes one 25 MHz instrument clock and an 8-bit register address.
 */
package rlc_pkg;

    // ****************************************
    // Register map
    // ****************************************
    localparam logic [7:0] REG_CFG = 8'h00;
    localparam logic [7:0] REG_STAT = 8'h04;
    localparam logic [7:0] REG_CTRL = 8'h08;

    localparam int CFG_ADDR_LSB = 0;
    localparam int CFG_TRIG_LSB = 8;
    localparam int CFG_BUS_SEL_BIT = 12;
    localparam int CFG_SRE_MAV_BIT = 13;
    localparam int CTRL_MAV_SET_BIT = 0;
    localparam int CTRL_MAV_CLR_BIT = 1;
    localparam int CTRL_CLR_ACK_BIT = 2;

    // ****************************************
    // Reset values, address limit and trigger modes
    // ****************************************
    localparam logic [4:0] ADDR_DEFAULT = 5'h04;
    localparam logic [4:0] ADDR_MAX = 5'h1e;
    localparam logic [1:0] TRIG_CONT = 2'h0;
    localparam logic [1:0] TRIG_GATE = 2'h1;
    localparam logic [1:0] TRIG_TRIG = 2'h2;
    localparam logic [1:0] TRIG_RESET = 2'h0;
    localparam logic [12:0] PINS_IDLE = 13'h1fe7;

    // ****************************************
    // Interface message codes (seven bits)
    // ****************************************
    localparam logic [6:0] CMD_GTL = 7'h01;
    localparam logic [6:0] CMD_SDC = 7'h04;
    localparam logic [6:0] CMD_GET = 7'h08;
    localparam logic [6:0] CMD_LLO = 7'h11;
    localparam logic [6:0] CMD_DCL = 7'h14;
    localparam logic [6:0] CMD_SPE = 7'h18;
    localparam logic [6:0] CMD_SPD = 7'h19;
    localparam logic [6:0] CMD_LAG = 7'h20;
    localparam logic [6:0] CMD_TAG = 7'h40;
    localparam logic [6:0] CMD_UNL = 7'h3f;
    localparam logic [6:0] CMD_UNT = 7'h5f;

    // ****************************************
    // State types
    // ****************************************
    typedef enum logic [1:0] {RL_LOCAL, RL_REMOTE, RL_LOCKOUT} rlc_mode_type;
    typedef enum logic [1:0] {AH_READY, AH_HOLD, AH_DONE} rlc_ah_type;

endpackage

// *** include/rlc_cmd_if.sv ***
/*
 * Carrier between the top and the interface message decoder.
 * Assumes the byte is already synchronised and in positive logic.
 */
interface rlc_cmd_if;
    logic [7:0] cmd_byte;
    logic [4:0] my_addr;
    logic is_mla;
    logic is_mta;
    logic is_ota;
    logic is_unl;
    logic is_unt;
    logic is_gtl;
    logic is_sdc;
    logic is_get;
    logic is_llo;
    logic is_dcl;
    logic is_spe;
    logic is_spd;
    modport dec (input cmd_byte, my_addr, output is_mla, is_mta, is_ota, is_unl, is_unt,
        is_gtl, is_sdc, is_get, is_llo, is_dcl, is_spe, is_spd);
    modport ctl (output cmd_byte, my_addr, input is_mla, is_mta, is_ota, is_unl, is_unt,
        is_gtl, is_sdc, is_get, is_llo, is_dcl, is_spe, is_spd);
endinterface

// *** logic/rlc_cmd_decode.sv ***
/*
 * Combinational decoder of interface message bytes sent under ATN.
 * Assumes the caller qualifies every flag with ATN and a taken byte.
 */
module rlc_cmd_decode (
    rlc_cmd_if.dec cmd
);
    import rlc_pkg::*;

    // ****************************************
    // Match helper
    // ****************************************
    function automatic logic code_is(input logic [7:0] b, input logic [6:0] code);
        code_is = (b[6:0] == code);
    endfunction

    // ****************************************
    // Decode
    // ****************************************
    wire [6:0] lag_code = CMD_LAG | {2'h0, cmd.my_addr};
    wire [6:0] tag_code = CMD_TAG | {2'h0, cmd.my_addr};
    wire any_tag = (cmd.cmd_byte[6:5] == 2'h2) && !code_is(cmd.cmd_byte, CMD_UNT);

    assign cmd.is_mla = code_is(cmd.cmd_byte, lag_code);
    assign cmd.is_mta = code_is(cmd.cmd_byte, tag_code);
    assign cmd.is_ota = any_tag && !cmd.is_mta;
    assign cmd.is_unl = code_is(cmd.cmd_byte, CMD_UNL);
    assign cmd.is_unt = code_is(cmd.cmd_byte, CMD_UNT);
    assign cmd.is_gtl = code_is(cmd.cmd_byte, CMD_GTL);
    assign cmd.is_sdc = code_is(cmd.cmd_byte, CMD_SDC);
    assign cmd.is_get = code_is(cmd.cmd_byte, CMD_GET);
    assign cmd.is_llo = code_is(cmd.cmd_byte, CMD_LLO);
    assign cmd.is_dcl = code_is(cmd.cmd_byte, CMD_DCL);
    assign cmd.is_spe = code_is(cmd.cmd_byte, CMD_SPE);
    assign cmd.is_spd = code_is(cmd.cmd_byte, CMD_SPD);

endmodule

// *** logic/rlc_top.sv ***
/*
 * Remote/local mode control and interface message responses.
 * Assumes bus pins arrive asynchronously, serial byte and trigger
 * acknowledge come from logic on clk, and the board resolves
 * the open-drain NRFD/NDAC wires from the enables.
 */
// Chosen here: the register addresses and the address-and-strobe port.
// Functional notes
// - Power-on reset always starts the block in local mode.
// - Remote indicator is off while in local mode.
// - First good serial byte moves local to remote.
// - In remote, panel keys are ignored except the escape key.
// - Remote indicator is on in remote and in lockout.
// - Serial control never reaches lockout; lockout only via bus.
// - Mode changes never reset any function setting.
// - Bus: REN false, escape key or addressed GTL return to local.
// - REN true plus own listen address enters remote.
// - LLO in remote, or remote entry after LLO, gives lockout.
// - Lockout ignores the escape key, else acts like remote.
// - GTL leaves lockout but the lockout memory stays set.
// - Only power-on, REN false or a bus select change clears lockout memory.
// - Talker with serial poll; own listen address unaddresses talker.
// - Listener; own talk address unaddresses listener; handshakes.
// - No parallel poll, extended addressing or controller.
// - One address 0 to 30 for listen and talk, default 4.
// - Addressed GET starts the manual trigger action.
// - GET ignored in continuous or gated trigger.
// - NDAC held after GET until trigger has started.
// - DCL or addressed SDC aborts I/O, clears buffers and MAV.
// - Device clear turns sweep, burst and modulation off.
// - NDAC held after clear until the processor acknowledges.
// - Summary status bit is recomputed after MAV clears.
module rlc_top (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    input wire logic ren_b,
    input wire logic atn_b,
    input wire logic dav_b,
    input wire logic [7:0] dio_b,
    input wire logic nrfd_in,
    output logic nrfd_out,
    output logic nrfd_oe_b,
    input wire logic ndac_in,
    output logic ndac_out,
    output logic ndac_oe_b,
    input wire logic ser_byte_ok,
    input wire logic escape_menu_key,
    input wire logic manual_trigger_key,
    input wire logic trig_started,
    output logic remote_led,
    output logic panel_keys_enable,
    output logic manual_trigger_start,
    output logic dev_clear,
    output logic func_off,
    output logic [7:0] rx_data,
    output logic rx_valid,
    output logic talker,
    output logic listener,
    output logic spoll,
    output logic mss
);
    import rlc_pkg::*;

    // ****************************************
    // Pin synchronisers
    // ****************************************
    logic [12:0] pins_s1_reg;
    logic [12:0] pins_s2_reg;
    logic [1:0] keys_prev_reg;
    wire [12:0] pins_raw = {dio_b, manual_trigger_key, escape_menu_key, dav_b, atn_b, ren_b};

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            pins_s1_reg <= PINS_IDLE;
            pins_s2_reg <= PINS_IDLE;
            keys_prev_reg <= 2'h0;
        end else begin
            pins_s1_reg <= pins_raw;
            pins_s2_reg <= pins_s1_reg;
            keys_prev_reg <= pins_s2_reg[4:3];
        end
    end

    wire ren_true = !pins_s2_reg[0];
    wire atn = !pins_s2_reg[1];
    wire dav = !pins_s2_reg[2];
    wire esc_rise = pins_s2_reg[3] && !keys_prev_reg[0];
    wire mkey_rise = pins_s2_reg[4] && !keys_prev_reg[1];
    wire [7:0] dio = ~pins_s2_reg[12:5];

    // ****************************************
    // Registers
    // ****************************************
    logic [4:0] addr_reg;
    logic [1:0] trig_mode_reg;
    logic bus_sel_reg;
    logic sre_mav_reg;
    logic mav_reg;
    logic [31:0] rdata_reg;

    wire cfg_wr = reg_wr && (reg_addr == REG_CFG);
    wire ctrl_wr = reg_wr && (reg_addr == REG_CTRL);
    wire [4:0] addr_wr = reg_wdata[CFG_ADDR_LSB +: 5];
    wire bus_sel_wr = reg_wdata[CFG_BUS_SEL_BIT];
    wire sel_change = cfg_wr && (bus_sel_wr != bus_sel_reg);
    wire mav_set = ctrl_wr && reg_wdata[CTRL_MAV_SET_BIT];
    wire mav_clr = ctrl_wr && reg_wdata[CTRL_MAV_CLR_BIT];
    wire clr_ack = ctrl_wr && reg_wdata[CTRL_CLR_ACK_BIT];

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            addr_reg <= ADDR_DEFAULT;
            trig_mode_reg <= TRIG_RESET;
            bus_sel_reg <= 1'b0;
            sre_mav_reg <= 1'b0;
        end else if (cfg_wr) begin
            if (addr_wr <= ADDR_MAX) begin
                addr_reg <= addr_wr;
            end
            trig_mode_reg <= reg_wdata[CFG_TRIG_LSB +: 2];
            bus_sel_reg <= bus_sel_wr;
            sre_mav_reg <= reg_wdata[CFG_SRE_MAV_BIT];
        end
    end

    // ****************************************
    // Message decode
    // ****************************************
    rlc_cmd_if cmd_bus ();

    assign cmd_bus.cmd_byte = dio;
    assign cmd_bus.my_addr = addr_reg;

    rlc_cmd_decode u_decode (
        .cmd (cmd_bus.dec)
    );

    rlc_ah_type ah_state_reg;
    rlc_mode_type rl_state_reg;
    rlc_mode_type rl_next;
    logic llo_mem_reg;
    logic llo_next;
    logic listener_reg;
    logic talker_reg;
    logic spoll_reg;
    logic wait_trig_reg;
    logic wait_ack_reg;

    wire acc_active = bus_sel_reg && (atn || listener_reg);
    wire take = (ah_state_reg == AH_READY) && acc_active && dav;
    wire cmd_ok = take && atn;
    wire data_ok = take && !atn && listener_reg;
    wire trig_ok = (trig_mode_reg != TRIG_CONT) && (trig_mode_reg != TRIG_GATE);
    wire c_mla = cmd_ok && cmd_bus.is_mla;
    wire c_mta = cmd_ok && cmd_bus.is_mta;
    wire c_ota = cmd_ok && cmd_bus.is_ota;
    wire c_unl = cmd_ok && cmd_bus.is_unl;
    wire c_unt = cmd_ok && cmd_bus.is_unt;
    wire c_llo = cmd_ok && cmd_bus.is_llo;
    wire c_dcl = cmd_ok && cmd_bus.is_dcl;
    wire c_spe = cmd_ok && cmd_bus.is_spe;
    wire c_spd = cmd_ok && cmd_bus.is_spd;
    wire c_gtl = cmd_ok && cmd_bus.is_gtl && listener_reg;
    wire c_sdc = cmd_ok && cmd_bus.is_sdc && listener_reg;
    wire c_get = cmd_ok && cmd_bus.is_get && listener_reg && trig_ok;
    wire clr_evt = c_dcl || c_sdc;
    wire ren_drop = bus_sel_reg && !ren_true;

    // ****************************************
    // Remote/local state
    // ****************************************
    always_comb begin
        rl_next = rl_state_reg;
        llo_next = llo_mem_reg;
        if (ren_drop || sel_change) begin
            rl_next = RL_LOCAL;
            llo_next = 1'b0;
        end else begin
            if (c_llo) begin
                llo_next = 1'b1;
            end
            case (rl_state_reg)
                RL_LOCAL: begin
                    if (!bus_sel_reg && ser_byte_ok) begin
                        rl_next = RL_REMOTE;
                    end else if (c_mla) begin
                        rl_next = (llo_mem_reg || c_llo) ? RL_LOCKOUT : RL_REMOTE;
                    end
                end
                RL_REMOTE: begin
                    if (c_gtl || esc_rise) begin
                        rl_next = RL_LOCAL;
                    end else if (c_llo) begin
                        rl_next = RL_LOCKOUT;
                    end
                end
                RL_LOCKOUT: begin
                    if (c_gtl) begin
                        rl_next = RL_LOCAL;
                    end
                end
                default: begin
                    rl_next = RL_LOCAL;
                end
            endcase
        end
    end

    // Only mode state changes here; settings registers stay untouched
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rl_state_reg <= RL_LOCAL;
            llo_mem_reg <= 1'b0;
            remote_led <= 1'b0;
            panel_keys_enable <= 1'b1;
        end else begin
            rl_state_reg <= rl_next;
            llo_mem_reg <= llo_next;
            remote_led <= (rl_next != RL_LOCAL);
            panel_keys_enable <= (rl_next == RL_LOCAL);
        end
    end

    // ****************************************
    // Talker and listener addressing
    // ****************************************
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            listener_reg <= 1'b0;
            talker_reg <= 1'b0;
            spoll_reg <= 1'b0;
        end else if (!bus_sel_reg) begin
            listener_reg <= 1'b0;
            talker_reg <= 1'b0;
            spoll_reg <= 1'b0;
        end else begin
            if (c_mla) begin
                listener_reg <= 1'b1;
            end else if (c_mta || c_unl) begin
                listener_reg <= 1'b0;
            end
            if (c_mta) begin
                talker_reg <= 1'b1;
            end else if (c_mla || c_unt || c_ota) begin
                talker_reg <= 1'b0;
            end
            if (c_spe || c_spd) begin
                spoll_reg <= c_spe;
            end
        end
    end

    assign listener = listener_reg;
    assign talker = talker_reg;
    assign spoll = spoll_reg;

    // ****************************************
    // Acceptor handshake with hold-off
    // ****************************************
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            wait_trig_reg <= 1'b0;
            wait_ack_reg <= 1'b0;
        end else begin
            wait_trig_reg <= c_get || (wait_trig_reg && !trig_started);
            wait_ack_reg <= clr_evt || (wait_ack_reg && !clr_ack);
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            ah_state_reg <= AH_READY;
            ndac_oe_b <= 1'b1;
            nrfd_oe_b <= 1'b1;
        end else begin
            case (ah_state_reg)
                AH_READY: begin
                    ndac_oe_b <= !acc_active;
                    nrfd_oe_b <= !take;
                    if (take) begin
                        ah_state_reg <= AH_HOLD;
                    end
                end
                AH_HOLD: begin
                    if (!wait_trig_reg && !wait_ack_reg) begin
                        ndac_oe_b <= 1'b1;
                        ah_state_reg <= AH_DONE;
                    end
                end
                AH_DONE: begin
                    if (!dav) begin
                        ndac_oe_b <= !acc_active;
                        nrfd_oe_b <= 1'b1;
                        ah_state_reg <= AH_READY;
                    end
                end
                default: begin
                    ah_state_reg <= AH_READY;
                end
            endcase
        end
    end

    // Open drain: only ever pulls low, enable low while pulling
    assign nrfd_out = 1'b0;
    assign ndac_out = 1'b0;

    // ****************************************
    // Trigger, clear and data outputs
    // ****************************************
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            manual_trigger_start <= 1'b0;
            dev_clear <= 1'b0;
            func_off <= 1'b0;
            rx_data <= 8'h00;
            rx_valid <= 1'b0;
        end else begin
            manual_trigger_start <= c_get || (mkey_rise && rl_state_reg == RL_LOCAL);
            dev_clear <= clr_evt;
            func_off <= clr_evt;
            rx_valid <= data_ok;
            if (data_ok) begin
                rx_data <= dio;
            end
        end
    end

    // Set wins over clear for MAV
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            mav_reg <= 1'b0;
            mss <= 1'b0;
        end else begin
            mav_reg <= mav_set || (mav_reg && !mav_clr && !clr_evt);
            mss <= sre_mav_reg && (mav_set || (mav_reg && !mav_clr && !clr_evt));
        end
    end

    // ****************************************
    // Register read port
    // ****************************************
    wire [31:0] cfg_word = {18'h0_0000, sre_mav_reg, bus_sel_reg, 2'h0, trig_mode_reg, 3'h0, addr_reg};
    wire [31:0] stat_word = {24'h00_0000, mss, mav_reg, wait_trig_reg || wait_ack_reg,
        listener_reg, talker_reg, llo_mem_reg, rl_state_reg};
    wire [31:0] rd_mux = (reg_addr == REG_CFG) ? cfg_word :
        (reg_addr == REG_STAT) ? stat_word : 32'h0000_0000;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rdata_reg <= 32'h0000_0000;
        end else begin
            rdata_reg <= reg_rd ? rd_mux : 32'h0000_0000;
        end
    end

    assign reg_rdata = rdata_reg;

    // ****************************************
    // Assertions
    // ****************************************
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);

    AST_LED_OFF_LOCAL: assert property (rl_state_reg == RL_LOCAL |-> !remote_led)
        else $error("Remote indicator lit in local mode");
    AST_LED_ON_REMOTE: assert property (rl_state_reg != RL_LOCAL |-> remote_led)
        else $error("Remote indicator dark in remote or lockout");
    AST_SERIAL_REMOTE: assert property (!bus_sel_reg && !sel_change && ser_byte_ok &&
        rl_state_reg == RL_LOCAL |=> rl_state_reg == RL_REMOTE)
        else $error("Serial byte did not enter remote");
    AST_SERIAL_NO_LOCKOUT: assert property (!bus_sel_reg |=> rl_state_reg != RL_LOCKOUT)
        else $error("Lockout reached under serial control");
    AST_ESC_IGNORED_LOCKOUT: assert property (rl_state_reg == RL_LOCKOUT && esc_rise &&
        !c_gtl && !ren_drop && !sel_change |=> rl_state_reg == RL_LOCKOUT)
        else $error("Escape key left lockout");
    AST_REN_FALSE_LOCAL: assert property (ren_drop |=> rl_state_reg == RL_LOCAL && !llo_mem_reg)
        else $error("REN false did not clear to local");
    AST_GTL_KEEPS_MEM: assert property (rl_state_reg == RL_LOCKOUT && c_gtl && !ren_drop &&
        !sel_change |=> rl_state_reg == RL_LOCAL && llo_mem_reg)
        else $error("Lockout memory lost on GTL");
    AST_GET_HOLDOFF: assert property (c_get |=> !ndac_oe_b [*2])
        else $error("NDAC released right after GET");
    AST_CLR_HOLDOFF: assert property (wait_ack_reg && !clr_ack |=> wait_ack_reg && !ndac_oe_b)
        else $error("NDAC released before clear acknowledge");
    AST_CLR_EFFECTS: assert property (clr_evt && !mav_set |=> dev_clear && func_off && !mav_reg)
        else $error("Device clear effects missing");
    AST_ADDR_RANGE: assert property (addr_reg <= ADDR_MAX)
        else $error("Bus address above 30");
    AST_MLA_REMOTE: assert property (c_mla && !sel_change && !ren_drop && rl_state_reg == RL_LOCAL &&
        !llo_mem_reg && !c_llo |=> rl_state_reg == RL_REMOTE)
        else $error("Listen address with REN true did not enter remote");

    COV_LOCKOUT: cover property (rl_state_reg == RL_REMOTE ##1 rl_state_reg == RL_LOCKOUT);
    COV_GET: cover property (c_get ##[1:40] trig_started);
    COV_CLEAR: cover property (clr_evt ##[1:40] clr_ack);

endmodule

// *** testbench/rlc_ctl_model.sv ***
/*
 * Bus controller model: sources bytes with ATN, DAV and data lines.
 * Assumes the bench resolves the NRFD and NDAC wires with pull-ups.
 */
module rlc_ctl_model (
    input wire logic clk,
    input wire logic nrfd_w,
    input wire logic ndac_w,
    output logic atn_b,
    output logic dav_b,
    output logic [7:0] dio_b
);
    timeunit 1ns;
    timeprecision 100ps;
    // ********
    // Source handshake
    // ********
    initial begin
        atn_b = 1'b1;
        dav_b = 1'b1;
        dio_b = 8'hff;
    end
    task automatic wait_lvl(input logic sel, input logic lvl, inout logic ok);
        int n;
        n = 0;
        while (((sel ? ndac_w : nrfd_w) !== lvl) && n < 400) begin
            @(posedge clk);
            #1;
            n++;
        end
        if (n >= 400) ok = 1'b0;
    endtask
    // Released lines float high through the pull-ups
    task automatic send(input logic [7:0] b, input logic atn, output logic ok);
        ok = 1'b1;
        @(posedge clk);
        #1;
        atn_b <= ~atn;
        dio_b <= ~b;
        wait_lvl(1'b0, 1'b1, ok);
        wait_lvl(1'b1, 1'b0, ok);
        dav_b <= 1'b0;
        @(posedge clk);
        #1;
        wait_lvl(1'b1, 1'b1, ok);
        dav_b <= 1'b1;
        dio_b <= 8'hff;
        atn_b <= 1'b1;
        wait_lvl(1'b0, 1'b1, ok);
    endtask
endmodule

// *** testbench/tb.sv ***
/*
 * Testbench of the remote/local bus control block.
 * Assumes the controller model and a 25 MHz clock.
 */
module tb;
    import rlc_pkg::*;
    timeunit 1ns;
    timeprecision 100ps;
    // Sre_mav, bus selected, trigger mode, address 5
    localparam logic [31:0] CFG_BUS = 32'h0000_3205;
    localparam logic [7:0] MLA = {1'b0, CMD_LAG | 7'h05};
    localparam logic [7:0] MTA = {1'b0, CMD_TAG | 7'h05};
    logic clk = 0, rst_b = 0, reg_wr = 0, reg_rd = 0, ren_b = 1, ser_byte_ok = 0;
    logic escape_menu_key = 0, manual_trigger_key = 0, trig_started = 0;
    logic [7:0] reg_addr = 0;
    logic [31:0] reg_wdata = 0, reg_rdata;
    logic atn_b, dav_b, nrfd_out, nrfd_oe_b, ndac_out, ndac_oe_b, nrfd_w, ndac_w;
    logic [7:0] dio_b, rx_data;
    logic remote_led, panel_keys_enable, manual_trigger_start, dev_clear, func_off;
    logic talker, listener, mss, spoll, rx_valid;
    int error_cnt = 0, n_checks = 0, mts_n = 0, clr_n = 0, off_n = 0, rx_n = 0;
    assign nrfd_w = nrfd_oe_b ? 1'b1 : nrfd_out;
    assign ndac_w = ndac_oe_b ? 1'b1 : ndac_out;
    always #20 clk = ~clk;
    always @(negedge clk) begin
        if (rx_valid === 1'b1) rx_n++;
        if (manual_trigger_start === 1'b1) mts_n++;
        if (dev_clear === 1'b1) clr_n++;
        if (func_off === 1'b1) off_n++;
    end
    rlc_ctl_model ctl (.clk(clk), .nrfd_w(nrfd_w), .ndac_w(ndac_w), .atn_b(atn_b), .dav_b(dav_b),
        .dio_b(dio_b));
    rlc_top uut (.clk(clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .ren_b(ren_b), .atn_b(atn_b), .dav_b(dav_b),
        .dio_b(dio_b), .nrfd_in(nrfd_w), .nrfd_out(nrfd_out), .nrfd_oe_b(nrfd_oe_b), .ndac_in(ndac_w),
        .ndac_out(ndac_out), .ndac_oe_b(ndac_oe_b), .ser_byte_ok(ser_byte_ok),
        .escape_menu_key(escape_menu_key), .manual_trigger_key(manual_trigger_key),
        .trig_started(trig_started), .remote_led(remote_led), .panel_keys_enable(panel_keys_enable),
        .manual_trigger_start(manual_trigger_start), .dev_clear(dev_clear), .func_off(func_off),
        .rx_data(rx_data), .rx_valid(rx_valid), .talker(talker), .listener(listener), .spoll(spoll), .mss(mss));
    // ********
    // Tasks
    // ********
    task automatic final_report;
        if (error_cnt == 0 && n_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
        #1;
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 chk(reg_rdata & m, e);
    endtask
    task automatic snd(input logic [7:0] b, input logic atn = 1'b1);
        logic ok;
        ctl.send(b, atn, ok);
        chk(ok, 1'b1);
        if (ok !== 1'b1) final_report();
        cyc(4);
    endtask
    task automatic key(input logic esc);
        if (esc) escape_menu_key <= 1'b1;
        else manual_trigger_key <= 1'b1;
        cyc(6);
        escape_menu_key <= 1'b0;
        manual_trigger_key <= 1'b0;
        cyc(6);
    endtask
    // ********
    // Sequence
    // ********
    initial begin
        repeat (100000) @(posedge clk);
        error_cnt++;
        final_report();
    end
    initial begin
        logic ok;
        logic [7:0] clr_cmd[2];
        clr_cmd = '{{1'b0, CMD_DCL}, {1'b0, CMD_SDC}};
        cyc(20);
        rst_b <= 1'b1;
        cyc(1);
        chk(remote_led, 1'b0);
        chk(panel_keys_enable, 1'b1);
        rd_chk(REG_CFG, 32'h0000_0004, 32'hffff_ffff);
        rd_chk(8'h0c, 32'h0, 32'hffff_ffff);
        key(1'b0);
        chk(mts_n, 1);
        ser_byte_ok <= 1'b1;
        @(posedge clk);
        ser_byte_ok <= 1'b0;
        cyc(2);
        chk(remote_led, 1'b1);
        key(1'b0);
        chk(mts_n, 1);
        key(1'b1);
        rd_chk(REG_STAT, 32'h0, 32'h7);
        wr(REG_CFG, CFG_BUS);
        wr(REG_CFG, CFG_BUS | 32'h0000_001f);
        ren_b <= 1'b0;
        rd_chk(REG_CFG, CFG_BUS, 32'hffff_ffff);
        snd({1'b0, CMD_LLO});
        snd(MLA);
        rd_chk(REG_STAT, 32'h6, 32'h7);
        chk(remote_led, 1'b1);
        key(1'b1);
        rd_chk(REG_STAT, 32'h6, 32'h7);
        snd({1'b0, CMD_GTL});
        rd_chk(REG_STAT, 32'h4, 32'h7);
        snd(MLA);
        rd_chk(REG_STAT, 32'h6, 32'h7);
        ren_b <= 1'b1;
        cyc(6);
        rd_chk(REG_STAT, 32'h0, 32'h7);
        ren_b <= 1'b0;
        cyc(6);
        snd(MLA);
        rd_chk(REG_STAT, 32'h1, 32'h7);
        snd({1'b0, CMD_LLO});
        rd_chk(REG_STAT, 32'h6, 32'h7);
        rd_chk(REG_CFG, CFG_BUS, 32'hffff_ffff);
        snd(MTA);
        chk({talker, listener}, 2'b10);
        snd(MLA);
        chk({talker, listener}, 2'b01);
        snd(8'h5a, 1'b0);
        chk(rx_data, 8'h5a);
        chk(rx_n, 1);
        snd({1'b0, CMD_SPE});
        chk(spoll, 1'b1);
        snd({1'b0, CMD_SPD});
        chk(spoll, 1'b0);
        fork
            ctl.send({1'b0, CMD_GET}, 1'b1, ok);
            begin
                cyc(30);
                chk(ndac_oe_b, 1'b0);
                trig_started <= 1'b1;
                @(posedge clk);
                trig_started <= 1'b0;
            end
        join
        chk(ok, 1'b1);
        if (ok !== 1'b1) final_report();
        chk(mts_n, 2);
        for (int m = 0; m < 2; m++) begin
            wr(REG_CFG, {CFG_BUS[31:10], m[1:0], CFG_BUS[7:0]});
            snd({1'b0, CMD_GET});
            chk(mts_n, 2);
        end
        wr(REG_CFG, CFG_BUS);
        for (int i = 0; i < 2; i++) begin
            wr(REG_CTRL, 32'h0000_0001);
            rd_chk(REG_STAT, 32'hc0, 32'hc0);
            fork
                ctl.send(clr_cmd[i], 1'b1, ok);
                begin
                    cyc(30);
                    chk(ndac_oe_b, 1'b0);
                    wr(REG_CTRL, 32'h0000_0004);
                end
            join
            cyc(4);
            chk(ok, 1'b1);
            if (ok !== 1'b1) final_report();
            rd_chk(REG_STAT, 32'h0, 32'hc0);
            chk(mss, 1'b0);
            chk(clr_n, i + 1);
            chk(off_n, i + 1);
        end
        final_report();
    end
endmodule
